/* File: include/dmac_map.vh */
// register offsets, field positions, reset values and timing counts for the display memory access block
// assumes a 50 MHz core clock and an external video timing block that pulses once per field
//
// Summary of operation
// - 16-bit mode: each character write copies the mode register attribute bits automatically.
// - 16-bit mode reads return character byte then attribute byte in one frame.
// - 8-bit mode: byte select 0 reaches character byte, 1 reaches attribute byte.
// - external sync: local background 0 shows video, 1 shows gray background level.
// - internal sync forces every character's local background bit to set.
// - blink attribute makes character blink using period and duty fields.
// - blink off phase shows video under external sync, gray under internal.
// - invert attribute swaps white and black pixels of the character.
// - clear bit zero-fills display memory, self-clears after about 20us, readable.
// - clear also runs at power-up, reset release and after software reset frame.
// - vertical-sync-clear bit: 0 clears at once, 1 waits for next vertical sync.
// - enabling auto-increment loads the 9-bit address as start, then advances per byte.
// - auto-increment uses 8-bit frames; in 8-bit mode byte select picks character or attribute, in 16-bit mode both are written.
// - all-ones byte ends auto-increment and is not stored.
// - setting the clear bit resets the auto-increment enable bit.
// - 9-bit address: high register bit 0 is msb, low register gives bits 7..0.
// - mode register written at 04h, read at 84h; read address sets top bit.
// - 3-bit background brightness selects 0% to 49% of white in 7% steps.
// - sync select picks auto, external or internal; auto follows loss-of-sync.
`ifndef DMAC_MAP_VH
`define DMAC_MAP_VH

`define DMAC_WR_VIDEO_MODE_ZERO 8'h00
`define DMAC_WR_MODE            8'h04
`define DMAC_WR_ADDR_HIGH       8'h05
`define DMAC_WR_ADDR_LOW        8'h06
`define DMAC_WR_DATA_IN         8'h07
`define DMAC_RD_FLAG            7
`define DMAC_RD_DATA_OUT_NIB    4'hb

`define DMAC_SOFT_RESET_BIT     1
`define DMAC_MODE_8BIT_BIT      6
`define DMAC_MODE_ATTR_HI       5
`define DMAC_MODE_ATTR_LO       3
`define DMAC_MODE_CLEAR_BIT     2
`define DMAC_MODE_VSYNC_CLR_BIT 1
`define DMAC_MODE_AUTO_INC_BIT  0
`define DMAC_ADDR_HIGH_SEL_BIT  1
`define DMAC_ADDR_HIGH_MSB_BIT  0

`define DMAC_MODE_RESET         8'h00
`define DMAC_ADDR_HIGH_RESET    8'h00
`define DMAC_ADDR_LOW_RESET     8'h00
`define DMAC_MODE_WR_MASK       8'h7b
`define DMAC_ADDR_HIGH_WR_MASK  8'h03
`define DMAC_ESCAPE_BYTE        8'hff

`define DMAC_DEPTH              512
`define DMAC_GRAY_STEP          6'h07
`define DMAC_CLK_MHZ            50
`define DMAC_CLEAR_TIME_US      20
`define DMAC_CLEAR_CYCLES       (`DMAC_CLEAR_TIME_US * `DMAC_CLK_MHZ)

`define DMAC_PIX_VIDEO          2'h0
`define DMAC_PIX_GRAY           2'h1
`define DMAC_PIX_WHITE          2'h2
`define DMAC_PIX_BLACK          2'h3

`endif

/* File: hdl/dmac_pixel_mux.v */
// per-pixel source selection from character attributes
// assumes glyph pixel codes 00 black, 10 white, others transparent
`timescale 1ns/100ps
`include "dmac_map.vh"

module dmac_pixel_mux (
  input  wire [1:0] glyphPixel,
  input  wire [2:0] charAttr,
  input  wire       internalSync,
  input  wire       backgroundMode,
  input  wire       blinkOn,
  output reg  [1:0] pixelSel
);

  wire local_background_select = charAttr[2] | internalSync;
  wire blink_select            = charAttr[1];
  wire invert_select           = charAttr[0];
  wire grayBack                = local_background_select | backgroundMode;

  always @* begin
    pixelSel = grayBack ? `DMAC_PIX_GRAY : `DMAC_PIX_VIDEO;
    if (blink_select && !blinkOn) begin
      pixelSel = internalSync ? `DMAC_PIX_GRAY : `DMAC_PIX_VIDEO;
    end else if (glyphPixel == 2'h2) begin
      pixelSel = invert_select ? `DMAC_PIX_BLACK : `DMAC_PIX_WHITE;
    end else if (glyphPixel == 2'h0) begin
      pixelSel = invert_select ? `DMAC_PIX_WHITE : `DMAC_PIX_BLACK;
    end
  end

endmodule

/* File: hdl/dmac_display_memory_ctrl.v */
// serial register port, display memory, clear sequencer and attribute rendering
// assumes serial pins come from another domain; video timing inputs are on clk
`timescale 1ns/100ps
`include "dmac_map.vh"

module dmac_display_memory_ctrl (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       csPin_n,
  input  wire       sclkPin,
  input  wire       sdinPin,
  output reg        sdout,
  output reg        sdoutEn_n,
  input  wire [1:0] syncSelect,
  input  wire       loss_of_sync_flag,
  input  wire       backgroundMode,
  input  wire [2:0] backgroundBrightness,
  input  wire [1:0] blinkTime,
  input  wire [1:0] blinkDuty,
  input  wire       fieldStart,
  input  wire [8:0] renderAddr,
  input  wire [1:0] glyphPixel,
  output reg  [7:0] renderChar,
  output reg  [1:0] pixelSel,
  output reg  [5:0] grayPercent,
  output wire       clearBusy
);

  localparam CLR_IDLE  = 2'h0;
  localparam CLR_WAITV = 2'h1;
  localparam CLR_SWEEP = 2'h2;
  localparam [9:0] CLEAR_LAST = `DMAC_CLEAR_CYCLES - 1;

  reg [1:0] rstSync;
  wire      rstIn_n = rstSync[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  // three-stage pin capture; a level is taken once stages two and three agree
  reg [2:0] csPipe;
  reg [2:0] sclkPipe;
  reg [2:0] sdinPipe;
  reg       csFilt;
  reg       sclkFilt;
  reg       sdinFilt;
  reg       csPrev;
  reg       sclkPrev;

  always @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      csPipe   <= 3'h7;
      sclkPipe <= 3'h0;
      sdinPipe <= 3'h0;
      csFilt   <= 1'b1;
      sclkFilt <= 1'b0;
      sdinFilt <= 1'b0;
      csPrev   <= 1'b1;
      sclkPrev <= 1'b0;
    end else begin
      csPipe   <= {csPipe[1:0], csPin_n};
      sclkPipe <= {sclkPipe[1:0], sclkPin};
      sdinPipe <= {sdinPipe[1:0], sdinPin};
      if (csPipe[1] == csPipe[2]) csFilt <= csPipe[2];
      if (sclkPipe[1] == sclkPipe[2]) sclkFilt <= sclkPipe[2];
      if (sdinPipe[1] == sdinPipe[2]) sdinFilt <= sdinPipe[2];
      csPrev   <= csFilt;
      sclkPrev <= sclkFilt;
    end
  end

  wire csFall   = csPrev & ~csFilt;
  wire csRise   = ~csPrev & csFilt;
  wire sclkRise = ~csFilt & ~sclkPrev & sclkFilt;
  wire sclkFall = ~csFilt & sclkPrev & ~sclkFilt;

  reg  [7:0] display_memory_mode_reg;
  reg  [7:0] display_address_high_reg;
  reg  [7:0] display_address_low_reg;
  reg  [8:0] autoAddr;
  reg  [1:0] clrState;
  reg  [9:0] clrCount;
  reg        clrRequest;
  reg  [15:0] rxShift;
  reg  [15:0] txShift;
  reg  [4:0] bitCount;
  reg        reading;
  reg  [7:0] charMem [0:`DMAC_DEPTH-1];
  reg  [2:0] attrMem [0:`DMAC_DEPTH-1];
  reg  [2:0] renderAttr;
  reg  [5:0] fieldCount;
  reg        blinkOn;

  wire [8:0] hostAddr = {display_address_high_reg[`DMAC_ADDR_HIGH_MSB_BIT], display_address_low_reg};
  wire       mode8Bit = display_memory_mode_reg[`DMAC_MODE_8BIT_BIT];
  wire       byteSel  = display_address_high_reg[`DMAC_ADDR_HIGH_SEL_BIT];
  wire       autoInc  = display_memory_mode_reg[`DMAC_MODE_AUTO_INC_BIT];
  wire [2:0] modeAttr = display_memory_mode_reg[`DMAC_MODE_ATTR_HI:`DMAC_MODE_ATTR_LO];
  assign clearBusy = clrRequest | (clrState != CLR_IDLE);

  // frame decode at the end of a frame
  wire [7:0] frameAddr = rxShift[15:8];
  wire [7:0] frameData = rxShift[7:0];
  wire       regWrite  = csRise & (bitCount == 5'd16) & ~frameAddr[`DMAC_RD_FLAG];
  wire       autoFrame = csRise & (bitCount == 5'd8) & autoInc & ~clearBusy;
  wire       escape    = autoFrame & (frameData == `DMAC_ESCAPE_BYTE);
  wire       softReset = regWrite & (frameAddr == `DMAC_WR_VIDEO_MODE_ZERO) &
                         frameData[`DMAC_SOFT_RESET_BIT];
  // writes to this bank are dropped while a clear runs
  wire       bankWrite = regWrite & ~clearBusy;
  wire       modeWrite = bankWrite & (frameAddr == `DMAC_WR_MODE);
  wire       dataWrite = bankWrite & (frameAddr == `DMAC_WR_DATA_IN);
  wire       autoWrite = autoFrame & ~escape;
  wire       clearSet  = softReset | (modeWrite & frameData[`DMAC_MODE_CLEAR_BIT]);

  always @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      display_memory_mode_reg  <= `DMAC_MODE_RESET;
      display_address_high_reg <= `DMAC_ADDR_HIGH_RESET;
      display_address_low_reg  <= `DMAC_ADDR_LOW_RESET;
      autoAddr                 <= 9'h000;
    end else if (softReset) begin
      display_memory_mode_reg  <= `DMAC_MODE_RESET;
      display_address_high_reg <= `DMAC_ADDR_HIGH_RESET;
      display_address_low_reg  <= `DMAC_ADDR_LOW_RESET;
    end else begin
      if (modeWrite) begin
        display_memory_mode_reg <= frameData & `DMAC_MODE_WR_MASK;
        if (frameData[`DMAC_MODE_CLEAR_BIT]) begin
          display_memory_mode_reg[`DMAC_MODE_AUTO_INC_BIT] <= 1'b0;
        end
        if (frameData[`DMAC_MODE_AUTO_INC_BIT] && !autoInc) begin
          autoAddr <= hostAddr;
        end
      end
      if (bankWrite && frameAddr == `DMAC_WR_ADDR_HIGH) begin
        display_address_high_reg <= frameData & `DMAC_ADDR_HIGH_WR_MASK;
      end
      if (bankWrite && frameAddr == `DMAC_WR_ADDR_LOW) begin
        display_address_low_reg <= frameData;
      end
      if (escape) begin
        display_memory_mode_reg[`DMAC_MODE_AUTO_INC_BIT] <= 1'b0;
      end
      if (autoWrite) begin
        autoAddr <= autoAddr + 9'h001;
      end
    end
  end

  // clear sequencer: sweep one entry per cycle, then hold busy for the full clear time
  always @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      clrRequest <= 1'b1;
      clrState   <= CLR_IDLE;
      clrCount   <= 10'h000;
    end else begin
      if (clearSet) begin
        clrRequest <= 1'b1;
      end
      case (clrState)
        CLR_IDLE: begin
          clrCount <= 10'h000;
          if (clrRequest && !csRise) begin
            clrRequest <= 1'b0;
            clrState   <= display_memory_mode_reg[`DMAC_MODE_VSYNC_CLR_BIT] ? CLR_WAITV : CLR_SWEEP;
          end
        end
        CLR_WAITV: begin
          if (fieldStart) clrState <= CLR_SWEEP;
        end
        CLR_SWEEP: begin
          clrCount <= clrCount + 10'h001;
          if (clrCount == CLEAR_LAST) clrState <= CLR_IDLE;
        end
        default: clrState <= CLR_IDLE;
      endcase
    end
  end

  // single write port into display memory
  reg       memWe;
  reg       memWeChar;
  reg       memWeAttr;
  reg [8:0] memIdx;
  reg [7:0] memChar;
  reg [2:0] memAttr;

  always @* begin
    memWe     = 1'b0;
    memWeChar = 1'b0;
    memWeAttr = 1'b0;
    memIdx    = autoWrite ? autoAddr : hostAddr;
    memChar   = frameData;
    memAttr   = mode8Bit ? frameData[7:5] : modeAttr;
    if (clrState == CLR_SWEEP) begin
      memWe     = ~clrCount[9];
      memWeChar = 1'b1;
      memWeAttr = 1'b1;
      memIdx    = clrCount[8:0];
      memChar   = 8'h00;
      memAttr   = 3'h0;
    end else if (dataWrite || autoWrite) begin
      memWe     = 1'b1;
      memWeChar = ~mode8Bit | ~byteSel;
      memWeAttr = ~mode8Bit | byteSel;
    end
  end

  genvar e;
  generate
    for (e = 0; e < `DMAC_DEPTH; e = e + 1) begin : gEntry
      always @(posedge clk) begin
        if (memWe && memIdx == e) begin
          if (memWeChar) charMem[e] <= memChar;
          if (memWeAttr) attrMem[e] <= memAttr;
        end
      end
    end
  endgenerate

  // serial shifter: data in on clock rise, out on clock fall, msb first
  reg [15:0] readWord;
  wire [7:0] firstByte = {rxShift[6:0], sdinFilt};

  always @* begin
    readWord = 16'h0000;
    case (firstByte)
      (`DMAC_WR_MODE | 8'h80): begin
        readWord = {display_memory_mode_reg[7:3], clearBusy, display_memory_mode_reg[1:0], 8'h00};
      end
      (`DMAC_WR_ADDR_HIGH | 8'h80): readWord = {display_address_high_reg, 8'h00};
      (`DMAC_WR_ADDR_LOW | 8'h80):  readWord = {display_address_low_reg, 8'h00};
      default: begin
        if (firstByte[7:4] == `DMAC_RD_DATA_OUT_NIB) begin
          if (!mode8Bit) begin
            readWord = {charMem[hostAddr], attrMem[hostAddr], 5'h00};
          end else if (byteSel) begin
            readWord = {attrMem[hostAddr], 5'h00, 8'h00};
          end else begin
            readWord = {charMem[hostAddr], 8'h00};
          end
        end
      end
    endcase
  end

  always @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      rxShift   <= 16'h0000;
      txShift   <= 16'h0000;
      bitCount  <= 5'h00;
      reading   <= 1'b0;
      sdout     <= 1'b0;
      sdoutEn_n <= 1'b1;
    end else begin
      if (csFall) begin
        bitCount <= 5'h00;
        rxShift  <= 16'h0000;
        reading  <= 1'b0;
      end else if (sclkRise) begin
        rxShift <= {rxShift[14:0], sdinFilt};
        if (bitCount != 5'h1f) bitCount <= bitCount + 5'h01;
        if (bitCount == 5'd7 && sdinFilt == 1'b0 && rxShift[6] == 1'b1) begin
          reading <= 1'b1;
          txShift <= readWord;
        end else if (bitCount == 5'd7 && rxShift[6]) begin
          reading <= 1'b1;
          txShift <= readWord;
        end
      end else if (sclkFall && reading) begin
        sdout   <= txShift[15];
        txShift <= {txShift[14:0], 1'b0};
      end
      if (csRise) reading <= 1'b0;
      sdoutEn_n <= csFilt | ~reading;
    end
  end

  // blink phase counted in fields; unit is 2, 4, 6 or 8 fields
  wire [5:0] blinkUnit = {3'h0, blinkTime, 1'b0} + 6'h02;
  reg  [5:0] onFields;
  reg  [5:0] offFields;

  always @* begin
    onFields  = blinkUnit;
    offFields = blinkUnit;
    case (blinkDuty)
      2'h1: offFields = blinkUnit + blinkUnit;
      2'h2: offFields = blinkUnit + blinkUnit + blinkUnit;
      2'h3: onFields  = blinkUnit + blinkUnit + blinkUnit;
      default: offFields = blinkUnit;
    endcase
  end

  always @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      fieldCount <= 6'h00;
      blinkOn    <= 1'b1;
    end else if (fieldStart) begin
      if (fieldCount + 6'h01 >= onFields + offFields) begin
        fieldCount <= 6'h00;
        blinkOn    <= 1'b1;
      end else begin
        fieldCount <= fieldCount + 6'h01;
        blinkOn    <= (fieldCount + 6'h01) < onFields;
      end
    end
  end

  // automatic sync picks internal only when sync is lost
  wire internalSync = syncSelect[1] ? syncSelect[0] : loss_of_sync_flag;
  wire [1:0] pixelNext;

  dmac_pixel_mux uPixelMux (
    .glyphPixel     (glyphPixel),
    .charAttr       (renderAttr),
    .internalSync   (internalSync),
    .backgroundMode (backgroundMode | internalSync),
    .blinkOn        (blinkOn),
    .pixelSel       (pixelNext)
  );

  always @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      renderChar  <= 8'h00;
      renderAttr  <= 3'h0;
      pixelSel    <= `DMAC_PIX_VIDEO;
      grayPercent <= 6'h00;
    end else begin
      renderChar  <= charMem[renderAddr];
      renderAttr  <= attrMem[renderAddr];
      pixelSel    <= pixelNext;
      grayPercent <= {3'h0, backgroundBrightness} * `DMAC_GRAY_STEP;
    end
  end

endmodule

/* File: verification/dmac_props.sv */
// port-level checker for the display memory access block
// assumes it is bound to dmac_display_memory_ctrl and sees only its ports
`timescale 1ns/100ps
module dmac_props (
  input wire       clk,
  input wire       rst_n,
  input wire       csPin_n,
  input wire       sdoutEn_n,
  input wire [1:0] syncSelect,
  input wire       loss_of_sync_flag,
  input wire       backgroundMode,
  input wire [2:0] backgroundBrightness,
  input wire       fieldStart,
  input wire [1:0] glyphPixel,
  input wire [1:0] pixelSel,
  input wire [5:0] grayPercent,
  input wire       clearBusy
);
  logic [11:0] busyCnt;
  // restarts on each field so a deferred clear is timed from its trigger
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      busyCnt <= 12'h000;
    else if (!clearBusy || fieldStart)
      busyCnt <= 12'h000;
    else
      busyCnt <= busyCnt + 12'h001;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_gray;
    $stable(backgroundBrightness) |=> grayPercent == {3'h0, $past(backgroundBrightness)} * 6'h07;
  endproperty
  a_gray: assert property (p_gray) else $error("gray level mismatch");
  property p_intBg;
    syncSelect == 2'h3 && glyphPixel[0] |=> pixelSel == 2'h1;
  endproperty
  a_intBg: assert property (p_intBg) else $error("internal sync background not gray");
  property p_losBg;
    !syncSelect[1] && loss_of_sync_flag && glyphPixel[0] |=> pixelSel == 2'h1;
  endproperty
  a_losBg: assert property (p_losBg) else $error("auto sync ignores sync loss");
  property p_bgMode;
    syncSelect == 2'h2 && backgroundMode && glyphPixel[0] |=> pixelSel == 2'h1;
  endproperty
  a_bgMode: assert property (p_bgMode) else $error("background mode not gray");
  property p_clrMax;
    busyCnt < 12'h44c;
  endproperty
  a_clrMax: assert property (p_clrMax) else $error("clear runs too long");
  property p_clrMin;
    $fell(clearBusy) |-> busyCnt >= 12'h3de;
  endproperty
  a_clrMin: assert property (p_clrMin) else $error("clear ended too early");
  property p_idle;
    csPin_n [*6] |-> sdoutEn_n;
  endproperty
  a_idle: assert property (p_idle) else $error("output driven while deselected");
  property p_powerClr;
    $rose(rst_n) |-> clearBusy;
  endproperty
  a_powerClr: assert property (p_powerClr) else $error("no clear after reset");
  c_clrDone: cover property ($fell(clearBusy));
  c_read: cover property ($fell(sdoutEn_n));
  c_intBg: cover property (syncSelect == 2'h3 && glyphPixel[0]);
endmodule

bind dmac_display_memory_ctrl dmac_props u_props (.clk(clk), .rst_n(rst_n), .csPin_n(csPin_n),
  .sdoutEn_n(sdoutEn_n), .syncSelect(syncSelect), .loss_of_sync_flag(loss_of_sync_flag),
  .backgroundMode(backgroundMode), .backgroundBrightness(backgroundBrightness), .fieldStart(fieldStart),
  .glyphPixel(glyphPixel), .pixelSel(pixelSel), .grayPercent(grayPercent), .clearBusy(clearBusy));

/* File: verification/dmac_host_model.sv */
// serial host model: frames msb first, reply sampled at sclk rise
// assumes the device filters pins on clk, so each level is held halfCyc clocks
`timescale 1ns/100ps
module dmac_host_model (
  input  wire clk,
  output reg  csPin_n,
  output reg  sclkPin,
  output reg  sdinPin,
  input  wire sdout
);
  int halfCyc = 5;
  initial begin
    csPin_n = 1'b1;
    sclkPin = 1'b0;
    sdinPin = 1'b0;
  end
  // sends the low n bits of w; bits after the first byte land in r
  task automatic xfer(input logic [23:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk) csPin_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (halfCyc) @(posedge clk);
      sdinPin <= w[i];
      repeat (halfCyc) @(posedge clk);
      sclkPin <= 1'b1;
      if (i < n - 8)
        r = {r[14:0], sdout};
      repeat (halfCyc) @(posedge clk);
      sclkPin <= 1'b0;
    end
    repeat (halfCyc) @(posedge clk);
    csPin_n <= 1'b1;
    // no pull on the data line, so leave it off its last value
    sdinPin <= ~sdinPin;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* File: verification/display_memory_access_control_tb.sv */
// self-checking bench for the display memory access block
// assumes the host model paces the serial pins; the bench drives the video side
`timescale 1ns/100ps
module display_memory_access_control_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        csPin_n, sclkPin, sdinPin, sdout, sdoutEn_n, clearBusy;
  logic        lossFlag = 1'b0;
  logic        bgMode = 1'b0;
  logic        fieldStart = 1'b0;
  logic [1:0]  syncSel = 2'h2;
  logic [1:0]  glyph = 2'h0;
  logic [2:0]  bright = 3'h0;
  logic [8:0]  rAddr = 9'h000;
  logic [7:0]  rChar, c;
  logic [1:0]  pixSel;
  logic [5:0]  gray;
  logic [15:0] rx;
  logic [8:0]  a1, a2, a3;
  logic [7:0]  memChar [512];
  logic [7:0]  memAttr [512];
  logic [7:0]  rdMap [4] = '{8'h84, 8'h85, 8'h86, 8'h9f};
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          nFields = 0;

  initial forever #10 clk = ~clk;

  dmac_display_memory_ctrl dut (.clk(clk), .rst_n(rst_n), .csPin_n(csPin_n), .sclkPin(sclkPin),
    .sdinPin(sdinPin), .sdout(sdout), .sdoutEn_n(sdoutEn_n), .syncSelect(syncSel),
    .loss_of_sync_flag(lossFlag), .backgroundMode(bgMode), .backgroundBrightness(bright),
    .blinkTime(2'h0), .blinkDuty(2'h0), .fieldStart(fieldStart), .renderAddr(rAddr),
    .glyphPixel(glyph), .renderChar(rChar), .pixelSel(pixSel), .grayPercent(gray),
    .clearBusy(clearBusy));
  dmac_host_model host (.clk(clk), .csPin_n(csPin_n), .sclkPin(sclkPin), .sdinPin(sdinPin), .sdout(sdout));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      wrap_up;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer({8'h00, a, d}, 16, rx);
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    host.xfer(n == 24 ? {a, 16'h0000} : {8'h00, a, 8'h00}, n, rx);
  endtask
  task automatic clearModel;
    for (int i = 0; i < 512; i++) begin
      memChar[i] = 8'h00;
      memAttr[i] = 8'h00;
    end
  endtask
  task automatic waitIdle;
    int k;
    k = 0;
    while (clearBusy !== 1'b0 && k < 1200) begin
      @(posedge clk);
      k++;
    end
    chk("clear busy", 16'h0000, {15'h0, clearBusy});
    clearModel;
  endtask
  task automatic see(input logic [8:0] a);
    @(posedge clk) rAddr <= a;
    repeat (3) @(posedge clk);
    chk("render char", {8'h00, memChar[a]}, {8'h00, rChar});
  endtask
  // one field pulse; blink unit is two fields at 1:1, so on for n%4 in {0,1}
  task automatic field;
    @(posedge clk) fieldStart <= 1'b1;
    @(posedge clk) fieldStart <= 1'b0;
    nFields++;
  endtask
  function automatic logic [1:0] expPix(input logic [7:0] at, input logic [1:0] g);
    logic intSync;
    intSync = syncSel == 2'h3 || (!syncSel[1] && lossFlag);
    if (at[6] && (nFields % 4) >= 2)
      return intSync ? 2'h1 : 2'h0;
    if (g[0])
      return (at[7] || bgMode || intSync) ? 2'h1 : 2'h0;
    return (g[1] ^ at[5]) ? 2'h2 : 2'h3;
  endfunction
  task automatic pixSweep(input logic [8:0] a);
    logic [1:0] g;
    see(a);
    for (int i = 0; i < 16; i++) begin
      g = 2'($urandom);
      @(posedge clk);
      {syncSel, lossFlag, bgMode} <= i[3:0];
      bright <= 3'(i);
      glyph <= g;
      repeat (3) @(posedge clk);
      chk("pixel source", {14'h0, expPix(memAttr[a], g)}, {14'h0, pixSel});
      chk("gray level", {13'h0, bright} * 16'h0007, {10'h0, gray});
    end
  endtask

  initial begin
    void'($urandom(97025));
    clearModel;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    waitIdle;
    foreach (rdMap[i]) begin
      rd(rdMap[i], 16);
      chk("reset value", 16'h0000, rx);
    end
    a1 = 9'($urandom);
    c = 8'($urandom_range(254));
    wr(8'h05, {7'h0, a1[8]});
    wr(8'h06, a1[7:0]);
    wr(8'h04, 8'h28);
    host.halfCyc = 9;
    wr(8'h07, c);
    host.halfCyc = 5;
    memChar[a1] = c;
    memAttr[a1] = 8'ha0;
    rd(8'h84, 16);
    chk("mode reg", 16'h0028, rx);
    rd(8'hb0, 24);
    chk("char and attr", {c, 8'ha0}, rx);
    pixSweep(a1);
    a2 = a1 ^ 9'h155;
    wr(8'h04, 8'h40);
    wr(8'h05, {7'h0, a2[8]});
    wr(8'h06, a2[7:0]);
    wr(8'h07, ~c);
    wr(8'h05, {6'h0, 1'b1, a2[8]});
    wr(8'h07, 8'h3f);
    memChar[a2] = ~c;
    memAttr[a2] = 8'h20;
    rd(8'hb0, 16);
    chk("attr byte", 16'h0020, rx);
    wr(8'h05, {7'h0, a2[8]});
    rd(8'hb0, 16);
    chk("char byte", {8'h00, ~c}, rx);
    pixSweep(a2);
    a3 = 9'($urandom);
    wr(8'h04, 8'h00);
    wr(8'h05, {7'h0, a3[8]});
    wr(8'h06, a3[7:0]);
    wr(8'h04, 8'h01);
    for (int i = 0; i < 3; i++) begin
      c = 8'($urandom_range(254));
      host.xfer({16'h0000, c}, 8, rx);
      memChar[9'(a3 + 9'(i))] = c;
    end
    host.xfer(24'h0000ff, 8, rx);
    rd(8'h84, 16);
    chk("auto mode bit", 16'h0000, rx);
    for (int i = 0; i < 4; i++)
      see(9'(a3 + 9'(i)));
    wr(8'h04, 8'h05);
    rd(8'h84, 16);
    chk("clear pending", 16'h0004, rx);
    for (int k = 0; k < 12 && rx[2] !== 1'b0; k++)
      rd(8'h84, 16);
    chk("clear bit", 16'h0000, rx);
    clearModel;
    see(a1);
    wr(8'h07, c);
    memChar[a3] = c;
    wr(8'h04, 8'h06);
    repeat (40) @(posedge clk);
    chk("deferred clear", 16'h0001, {15'h0, clearBusy});
    see(a3);
    field;
    waitIdle;
    see(a3);
    wr(8'h05, 8'h03);
    wr(8'h00, 8'h02);
    chk("soft reset clear", 16'h0001, {15'h0, clearBusy});
    waitIdle;
    rd(8'h85, 16);
    chk("high reg reset", 16'h0000, rx);
    wr(8'h04, 8'h10);
    wr(8'h07, c);
    memChar[0] = c;
    memAttr[0] = 8'h40;
    see(9'h000);
    lossFlag <= 1'b0;
    bgMode <= 1'b0;
    glyph <= 2'h2;
    for (int i = 0; i < 8; i++) begin
      if (!i[0])
        field;
      @(posedge clk) syncSel <= {1'b1, i[0]};
      repeat (3) @(posedge clk);
      chk("blink pixel", {14'h0, expPix(memAttr[0], 2'h2)}, {14'h0, pixSel});
    end
    wrap_up;
  end
endmodule
